// ---- inc/imsc_regs.vh ----
// constants of the input monitor / output phase offset register block
// assumes a 10 MHz core clock and a host on the serial management port
//
// Function
// - monitor enable register resets to all ones, every monitor enabled
// - input 2 loss select: two-bit field split, low bit 5; 10 slow, 11 normal
// - input 1 loss select: split field, low bit 4, same encoding
// - slow loss detector reacts later and less sensitively than normal one
// - bit 1 enables input 2 offset monitor, bit 0 input 1
// - each output has a signed 8-bit phase offset in divider cycles
// - output 1 phase offset resets to zero
// - low reset returns all logic and registers to their defaults
// - clock outputs float while reset is applied
// - pin 1 is interrupt, else input 1 alarm if selected, else floats
// - pin 2 shows input 2 alarm when selected, else floats

`ifndef IMSC_REGS_VH
`define IMSC_REGS_VH

// ******************************************************************
// register offsets
// ******************************************************************
`define IMSC_ADDR_LOSS_HI       8'h8a
`define IMSC_ADDR_MON_EN        8'h8b
`define IMSC_ADDR_OUT1_PHASE    8'h8e
`define IMSC_ADDR_OUT2_PHASE    8'h8f

// ******************************************************************
// field positions
// ******************************************************************
`define IMSC_HI_IN2_LOSS_BIT    1
`define IMSC_HI_IN1_LOSS_BIT    0
`define IMSC_EN_IN2_LOSS_BIT    5
`define IMSC_EN_IN1_LOSS_BIT    4
`define IMSC_EN_IN2_FOS_BIT     1
`define IMSC_EN_IN1_FOS_BIT     0
`define IMSC_EN_RSVD_MASK       8'hcc

// ******************************************************************
// reset values
// ******************************************************************
`define IMSC_RST_LOSS_HI        8'h03
`define IMSC_RST_MON_EN         8'hff
`define IMSC_RST_OUT1_PHASE     8'h00
`define IMSC_RST_OUT2_PHASE     8'h00

// ******************************************************************
// loss select codes
// ******************************************************************
`define IMSC_LOSS_OFF           2'h0
`define IMSC_LOSS_SLOW          2'h2
`define IMSC_LOSS_NORMAL        2'h3

// ******************************************************************
// serial frame: command byte, address byte, data byte
// ******************************************************************
`define IMSC_CMD_WRITE          8'h40
`define IMSC_CMD_READ           8'h80
`define IMSC_HDR_BITS           5'h10
`define IMSC_FRAME_BITS         5'h18

// ******************************************************************
// timing
// ******************************************************************
`define IMSC_CLK_HZ             10000000
`define IMSC_SWRST_WAIT_MS      10
`define IMSC_SWRST_WAIT_CYC     ((`IMSC_SWRST_WAIT_MS * `IMSC_CLK_HZ) / 1000)
`define IMSC_LOS_CYC            16
`define IMSC_SLOW_LOSS_DETECTOR_CYC           64
`define IMSC_SLOW_LOSS_DETECTOR_CLR_EDGES     4
`define IMSC_FOS_WIN_CYC        256
`define IMSC_FOS_EXP_EDGES      32
`define IMSC_FOS_TOL_EDGES      2

`endif

// ---- verilog/imsc_in_mon.v ----
// one input clock monitor: signal loss (normal or slow) and frequency offset
// assumes the input clock is sampled as a level synchronous to clk
`timescale 1ns/10ps
`include "imsc_regs.vh"

module imsc_in_mon #(
	parameter LOS_CYC   = `IMSC_LOS_CYC,
	parameter SLOW_LOSS_DETECTOR_CYC  = `IMSC_SLOW_LOSS_DETECTOR_CYC,
	parameter CLR_EDGES = `IMSC_SLOW_LOSS_DETECTOR_CLR_EDGES,
	parameter WIN_CYC   = `IMSC_FOS_WIN_CYC,
	parameter EXP_EDGES = `IMSC_FOS_EXP_EDGES,
	parameter TOL_EDGES = `IMSC_FOS_TOL_EDGES
) (
	input  wire       clk,
	input  wire       rst_b,
	input  wire       clk_in,
	input  wire [1:0] loss_sel,
	input  wire       fos_on,
	output reg        loss_q,
	output reg        fos_q
);
	reg  [15:0] idle_q;
	reg  [15:0] win_q;
	reg  [15:0] edges_q;
	reg  [3:0]  good_q;
	reg         prev_q;
	wire        edge_seen;
	wire        slow;
	wire        on;
	wire        win_end;

	assign edge_seen = clk_in & ~prev_q;
	assign slow      = (loss_sel == `IMSC_LOSS_SLOW);
	assign on        = (loss_sel == `IMSC_LOSS_SLOW) |
	                   (loss_sel == `IMSC_LOSS_NORMAL);
	assign win_end   = (win_q == WIN_CYC - 1);

	// ******************************************************************
	// signal loss
	// ******************************************************************
	// slow variant needs a longer silence and several edges to clear
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prev_q <= 1'b0;
			idle_q <= 16'h0000;
			good_q <= 4'h0;
			loss_q <= 1'b0;
		end else begin
			prev_q <= clk_in;
			if (edge_seen)
				idle_q <= 16'h0000;
			else if (idle_q != 16'hffff)
				idle_q <= idle_q + 16'h0001;
			if (!on) begin
				loss_q <= 1'b0;
				good_q <= 4'h0;
			end else if (!edge_seen) begin
				if (idle_q >= (slow ? SLOW_LOSS_DETECTOR_CYC : LOS_CYC)) begin
					loss_q <= 1'b1;
					good_q <= 4'h0;
				end
			end else if (!slow || good_q >= CLR_EDGES - 1) begin
				loss_q <= 1'b0;
			end else begin
				good_q <= good_q + 4'h1;
			end
		end
	end

	// ******************************************************************
	// frequency offset: edge count per window against expectation
	// ******************************************************************
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			win_q   <= 16'h0000;
			edges_q <= 16'h0000;
			fos_q   <= 1'b0;
		end else begin
			win_q <= win_end ? 16'h0000 : win_q + 16'h0001;
			if (win_end)
				edges_q <= 16'h0000;
			else if (edge_seen)
				edges_q <= edges_q + 16'h0001;
			if (!fos_on)
				fos_q <= 1'b0;
			else if (win_end)
				fos_q <= (edges_q < EXP_EDGES - TOL_EDGES) |
				         (edges_q > EXP_EDGES + TOL_EDGES);
		end
	end
endmodule // imsc_in_mon

// ---- verilog/imsc_phase_out.v ----
// one output clock: square wave from an 8-bit divider with phase offset
// assumes the core clock stands in for the high-speed divider clock
`timescale 1ns/10ps
`include "imsc_regs.vh"

module imsc_phase_out (
	input  wire       clk,
	input  wire       rst_b,
	input  wire       run,
	input  wire [7:0] offset,
	output reg        clk_out,
	output reg        clk_oe_b
);
	reg  [7:0] cnt_q;
	reg  [7:0] cnt_d;
	reg  [7:0] off_q;

	// a change of the signed offset moves the phase by the difference;
	// arithmetic is mod 256 so two's complement wraps for free
	always @* begin
		cnt_d = cnt_q + 8'h01 + (offset - off_q);
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q    <= 8'h00;
			off_q    <= 8'h00;
			clk_out  <= 1'b0;
			clk_oe_b <= 1'b1;
		end else begin
			cnt_q    <= cnt_d;
			off_q    <= offset;
			clk_out  <= cnt_d[7];
			clk_oe_b <= ~run;
		end
	end
endmodule // imsc_phase_out

// ---- verilog/imsc_top.v ----
// monitor enable and output phase offset registers behind the serial port
// assumes SCLK, SS_B and MOSI are synchronous to CLOCK and much slower
`timescale 1ns/10ps
`include "imsc_regs.vh"

module imsc_top (
	input  wire CLOCK,
	input  wire RST_B,
	input  wire SCLK,
	input  wire SS_B,
	input  wire MOSI,
	output reg  MISO,
	output reg  MISO_OE_B,
	input  wire INPUT_CLOCK_1,
	input  wire INPUT_CLOCK_2,
	input  wire IRQ_PIN_SELECT,
	input  wire IN1_ALARM_PIN_SELECT,
	input  wire IN2_ALARM_PIN_SELECT,
	output reg  IRQ_OR_IN1_ALARM_PIN,
	output reg  IRQ_OR_IN1_ALARM_PIN_OE_B,
	output reg  IN2_ALARM_PIN,
	output reg  IN2_ALARM_PIN_OE_B,
	output wire OUT1_CLK,
	output wire OUT1_CLK_OE_B,
	output wire OUT2_CLK,
	output wire OUT2_CLK_OE_B
);

	// ******************************************************************
	// declarations
	// ******************************************************************
	reg         sclk_q;
	reg  [4:0]  bit_cnt_q;
	reg  [4:0]  bit_cnt_d;
	reg  [7:0]  cmd_q;
	reg  [7:0]  addr_q;
	reg  [7:0]  shift_q;
	reg  [7:0]  rd_sh_q;
	reg  [7:0]  rd_data;
	reg         reading_q;
	reg         wr_stb;
	reg  [7:0]  wr_addr;
	reg  [7:0]  wr_data;
	reg  [1:0]  loss_hi_q;
	reg  [1:0]  loss_lo_q;
	reg  [1:0]  fos_on_q;
	reg  [7:0]  out1_phase_q;
	reg  [7:0]  out2_phase_q;
	reg         programmed_q;
	reg  [1:0]  loss_hi_d;
	reg  [1:0]  loss_lo_d;
	reg  [1:0]  fos_on_d;
	reg  [7:0]  out1_phase_d;
	reg  [7:0]  out2_phase_d;
	reg         programmed_d;
	wire        sclk_rise;
	wire        sclk_fall;
	wire        active;
	wire [7:0]  shift_in;
	wire [1:0]  in_clk;
	wire [1:0]  loss_alarm;
	wire [1:0]  fos_alarm;
	wire [1:0]  signal_loss_alarm;
	wire [1:0]  in1_loss_monitor_select;
	wire [1:0]  in2_loss_monitor_select;
	wire [1:0]  out_clk;
	wire [1:0]  out_oe_b;
	wire [15:0] out_phase;
	wire        irq_raw;

	// reset images, so single bits can be picked at their field positions
	localparam [7:0] LOSS_HI_RST = `IMSC_RST_LOSS_HI;
	localparam [7:0] MON_EN_RST  = `IMSC_RST_MON_EN;

	assign active   = ~SS_B;
	assign sclk_rise = active & SCLK & ~sclk_q;
	assign sclk_fall = active & ~SCLK & sclk_q;
	assign shift_in = {shift_q[6:0], MOSI};

	// ******************************************************************
	// serial frame: command, address, data, MSB first, mode 0
	// ******************************************************************
	always @* begin
		bit_cnt_d = bit_cnt_q;
		if (!active)
			bit_cnt_d = 5'h00;
		else if (sclk_rise && bit_cnt_q != `IMSC_FRAME_BITS)
			bit_cnt_d = bit_cnt_q + 5'h01;
	end

	always @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			sclk_q    <= 1'b0;
			bit_cnt_q <= 5'h00;
			cmd_q     <= 8'h00;
			addr_q    <= 8'h00;
			shift_q   <= 8'h00;
			reading_q <= 1'b0;
		end else begin
			sclk_q    <= SCLK;
			bit_cnt_q <= bit_cnt_d;
			if (!active) begin
				reading_q <= 1'b0;
			end else if (sclk_rise) begin
				shift_q <= shift_in;
				if (bit_cnt_q == 5'h07)
					cmd_q <= shift_in;
				if (bit_cnt_q == 5'h0f) begin
					addr_q    <= shift_in;
					reading_q <= (cmd_q == `IMSC_CMD_READ);
				end
			end
		end
	end

	// write commits on the last rising edge of a full write frame
	always @* begin
		wr_stb  = active & sclk_rise & (bit_cnt_q == 5'h17) &
		          (cmd_q == `IMSC_CMD_WRITE);
		wr_addr = addr_q;
		wr_data = shift_in;
	end

	// ******************************************************************
	// read data: loaded after the header, shifted out on falling edges
	// ******************************************************************
	// decode the address as it arrives; addr_q only loads on that edge
	always @* begin
		case (shift_in)
		`IMSC_ADDR_LOSS_HI:
			rd_data = {6'h00, loss_hi_q};
		`IMSC_ADDR_MON_EN:
			rd_data = `IMSC_EN_RSVD_MASK |
			          {2'h0, loss_lo_q, 2'h0, fos_on_q};
		`IMSC_ADDR_OUT1_PHASE:
			rd_data = out1_phase_q;
		`IMSC_ADDR_OUT2_PHASE:
			rd_data = out2_phase_q;
		default:
			rd_data = 8'h00;
		endcase
	end

	always @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			rd_sh_q   <= 8'h00;
			MISO      <= 1'b0;
			MISO_OE_B <= 1'b1;
		end else begin
			if (!active || !reading_q) begin
				MISO_OE_B <= 1'b1;
				MISO      <= 1'b0;
				if (sclk_rise && bit_cnt_q == 5'h0f)
					rd_sh_q <= rd_data;
			end else if (sclk_fall &&
			             bit_cnt_q >= `IMSC_HDR_BITS &&
			             bit_cnt_q < `IMSC_FRAME_BITS) begin
				MISO_OE_B <= 1'b0;
				MISO      <= rd_sh_q[7];
				rd_sh_q   <= {rd_sh_q[6:0], 1'b0};
			end
		end
	end

	// ******************************************************************
	// registers
	// ******************************************************************
	// the loss select halves sit in two registers; the upper half's
	// reset value is chosen so that both inputs start on the normal
	// detector, matching the all-ones monitor enable register
	always @* begin
		loss_hi_d    = loss_hi_q;
		loss_lo_d    = loss_lo_q;
		fos_on_d     = fos_on_q;
		out1_phase_d = out1_phase_q;
		out2_phase_d = out2_phase_q;
		programmed_d = programmed_q;
		if (wr_stb) begin
			case (wr_addr)
			`IMSC_ADDR_LOSS_HI: begin
				loss_hi_d[1] = wr_data[`IMSC_HI_IN2_LOSS_BIT];
				loss_hi_d[0] = wr_data[`IMSC_HI_IN1_LOSS_BIT];
				programmed_d = 1'b1;
			end
			`IMSC_ADDR_MON_EN: begin
				loss_lo_d[1] = wr_data[`IMSC_EN_IN2_LOSS_BIT];
				loss_lo_d[0] = wr_data[`IMSC_EN_IN1_LOSS_BIT];
				fos_on_d[1]  = wr_data[`IMSC_EN_IN2_FOS_BIT];
				fos_on_d[0]  = wr_data[`IMSC_EN_IN1_FOS_BIT];
				programmed_d = 1'b1;
			end
			`IMSC_ADDR_OUT1_PHASE: begin
				out1_phase_d = wr_data;
				programmed_d = 1'b1;
			end
			`IMSC_ADDR_OUT2_PHASE: begin
				out2_phase_d = wr_data;
				programmed_d = 1'b1;
			end
			default: begin
				programmed_d = programmed_q;
			end
			endcase
		end
	end

	// reserved bits have no storage, so writes to them cannot stick
	always @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			loss_hi_q    <= LOSS_HI_RST[1:0];
			loss_lo_q    <= {MON_EN_RST[`IMSC_EN_IN2_LOSS_BIT],
			                 MON_EN_RST[`IMSC_EN_IN1_LOSS_BIT]};
			fos_on_q     <= {MON_EN_RST[`IMSC_EN_IN2_FOS_BIT],
			                 MON_EN_RST[`IMSC_EN_IN1_FOS_BIT]};
			out1_phase_q <= `IMSC_RST_OUT1_PHASE;
			out2_phase_q <= `IMSC_RST_OUT2_PHASE;
			programmed_q <= 1'b0;
		end else begin
			loss_hi_q    <= loss_hi_d;
			loss_lo_q    <= loss_lo_d;
			fos_on_q     <= fos_on_d;
			out1_phase_q <= out1_phase_d;
			out2_phase_q <= out2_phase_d;
			programmed_q <= programmed_d;
		end
	end

	// ******************************************************************
	// input monitors
	// ******************************************************************
	assign in_clk                  = {INPUT_CLOCK_2, INPUT_CLOCK_1};
	assign in2_loss_monitor_select = {loss_hi_q[1], loss_lo_q[1]};
	assign in1_loss_monitor_select = {loss_hi_q[0], loss_lo_q[0]};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_mon
			imsc_in_mon u_mon (
				.clk      (CLOCK),
				.rst_b    (RST_B),
				.clk_in   (in_clk[gi]),
				.loss_sel (gi == 0 ? in1_loss_monitor_select :
				                     in2_loss_monitor_select),
				.fos_on   (fos_on_q[gi]),
				.loss_q   (loss_alarm[gi]),
				.fos_q    (fos_alarm[gi])
			);
			// pin alarm is loss, widened by offset when that monitor is on
			assign signal_loss_alarm[gi] = loss_alarm[gi] | fos_alarm[gi];
		end
	endgenerate

	// masking and polarity live elsewhere; the raw request is any alarm
	assign irq_raw = |signal_loss_alarm;

	// ******************************************************************
	// indicator pins
	// ******************************************************************
	always @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			IRQ_OR_IN1_ALARM_PIN      <= 1'b0;
			IRQ_OR_IN1_ALARM_PIN_OE_B <= 1'b1;
			IN2_ALARM_PIN             <= 1'b0;
			IN2_ALARM_PIN_OE_B        <= 1'b1;
		end else begin
			if (IRQ_PIN_SELECT) begin
				IRQ_OR_IN1_ALARM_PIN      <= irq_raw;
				IRQ_OR_IN1_ALARM_PIN_OE_B <= 1'b0;
			end else if (IN1_ALARM_PIN_SELECT) begin
				IRQ_OR_IN1_ALARM_PIN      <= signal_loss_alarm[0];
				IRQ_OR_IN1_ALARM_PIN_OE_B <= 1'b0;
			end else begin
				IRQ_OR_IN1_ALARM_PIN      <= 1'b0;
				IRQ_OR_IN1_ALARM_PIN_OE_B <= 1'b1;
			end
			IN2_ALARM_PIN      <= IN2_ALARM_PIN_SELECT &
			                      signal_loss_alarm[1];
			IN2_ALARM_PIN_OE_B <= ~IN2_ALARM_PIN_SELECT;
		end
	end

	// ******************************************************************
	// output clocks
	// ******************************************************************
	// outputs stay floating until the host has written a register, so
	// defaults alone never start a clock
	assign out_phase = {out2_phase_q, out1_phase_q};

	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_out
			imsc_phase_out u_out (
				.clk      (CLOCK),
				.rst_b    (RST_B),
				.run      (programmed_q),
				.offset   (out_phase[gi*8 +: 8]),
				.clk_out  (out_clk[gi]),
				.clk_oe_b (out_oe_b[gi])
			);
		end
	endgenerate

	assign OUT1_CLK      = out_clk[0];
	assign OUT1_CLK_OE_B = out_oe_b[0];
	assign OUT2_CLK      = out_clk[1];
	assign OUT2_CLK_OE_B = out_oe_b[1];

endmodule // imsc_top

// ---- sim/imsc_chk.sv ----
// checker of imsc_top: alarm pins, output enables, serial data enable
// assumes binding onto imsc_top, one clock domain, async reset
`timescale 1ns/10ps

module imsc_chk (
	input wire CLOCK,
	input wire RST_B,
	input wire SS_B,
	input wire MISO_OE_B,
	input wire IRQ_PIN_SELECT,
	input wire IN1_ALARM_PIN_SELECT,
	input wire IN2_ALARM_PIN_SELECT,
	input wire IRQ_OR_IN1_ALARM_PIN,
	input wire IRQ_OR_IN1_ALARM_PIN_OE_B,
	input wire IN2_ALARM_PIN,
	input wire IN2_ALARM_PIN_OE_B,
	input wire OUT1_CLK_OE_B,
	input wire OUT2_CLK_OE_B
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_B);
	// ****************************************
	// properties
	// ****************************************
	a_rst_float: assert property (
		$rose(RST_B) |-> $past(OUT1_CLK_OE_B && OUT2_CLK_OE_B))
		else $error("output clock driven in reset");
	a_oe_in_frame: assert property (
		$fell(OUT1_CLK_OE_B) |-> $past(!SS_B))
		else $error("output clock enabled outside a frame");
	a_oe_pair: assert property (
		OUT1_CLK_OE_B == OUT2_CLK_OE_B)
		else $error("output enables differ");
	a_oe_hold: assert property (
		!OUT1_CLK_OE_B |=> !OUT1_CLK_OE_B)
		else $error("output clock released");
	a_pin2_float: assert property (
		!IN2_ALARM_PIN_SELECT |=> IN2_ALARM_PIN_OE_B)
		else $error("pin 2 driven unselected");
	a_pin2_drive: assert property (
		IN2_ALARM_PIN_SELECT |=> !IN2_ALARM_PIN_OE_B)
		else $error("pin 2 floats selected");
	a_irq_drive: assert property (
		IRQ_PIN_SELECT |=> !IRQ_OR_IN1_ALARM_PIN_OE_B)
		else $error("pin 1 floats as interrupt");
	a_pin1_float: assert property (
		!IRQ_PIN_SELECT && !IN1_ALARM_PIN_SELECT |=> IRQ_OR_IN1_ALARM_PIN_OE_B)
		else $error("pin 1 driven unselected");
	a_irq_merge: assert property (
		IRQ_PIN_SELECT && IN2_ALARM_PIN_SELECT ##1 IN2_ALARM_PIN
		|-> IRQ_OR_IN1_ALARM_PIN)
		else $error("interrupt misses input 2 alarm");
	a_miso_float: assert property (
		SS_B |=> MISO_OE_B)
		else $error("serial data driven unselected");
	c_read: cover property (!MISO_OE_B);
	c_alarm2: cover property (IN2_ALARM_PIN && !IN2_ALARM_PIN_OE_B);
	c_prog: cover property ($fell(OUT1_CLK_OE_B));
endmodule // imsc_chk

bind imsc_top imsc_chk i_chk (.CLOCK(CLOCK), .RST_B(RST_B), .SS_B(SS_B),
	.MISO_OE_B(MISO_OE_B), .IRQ_PIN_SELECT(IRQ_PIN_SELECT),
	.IN1_ALARM_PIN_SELECT(IN1_ALARM_PIN_SELECT),
	.IN2_ALARM_PIN_SELECT(IN2_ALARM_PIN_SELECT),
	.IRQ_OR_IN1_ALARM_PIN(IRQ_OR_IN1_ALARM_PIN),
	.IRQ_OR_IN1_ALARM_PIN_OE_B(IRQ_OR_IN1_ALARM_PIN_OE_B),
	.IN2_ALARM_PIN(IN2_ALARM_PIN), .IN2_ALARM_PIN_OE_B(IN2_ALARM_PIN_OE_B),
	.OUT1_CLK_OE_B(OUT1_CLK_OE_B), .OUT2_CLK_OE_B(OUT2_CLK_OE_B));

// ---- sim/imsc_host.sv ----
// host on the serial management port: 24-bit frames, msb first
// assumes the block samples sclk with its core clock
`timescale 1ns/10ps
`include "imsc_regs.vh"

module imsc_host (
	input  wire       clk,
	output reg        sclk,
	output reg        ss_b,
	output reg        mosi,
	input  wire       miso,
	input  wire       miso_oe_b,
	output reg        rd_stb,
	output reg  [7:0] rd_val
);
	// clocks per sclk phase; 3 keeps a margin over the 1 needed
	integer hold = 3;

	initial begin
		sclk = 1'b0;
		ss_b = 1'b1;
		mosi = 1'b0;
		rd_stb = 1'b0;
		rd_val = 8'h00;
	end

	task xfer(input [7:0] cmd, input [7:0] adr, input [7:0] wd);
		reg [23:0] f;
		integer i;
		f = {cmd, adr, wd};
		@(posedge clk) #1;
		ss_b = 1'b0;
		for (i = 23; i >= 0; i = i - 1) begin
			mosi = f[i];
			repeat (hold) @(posedge clk);
			#1;
			// a released line reads unknown so it can never match
			if (i < 8)
				rd_val[i] = miso_oe_b ? 1'bx : miso;
			sclk = 1'b1;
			repeat (hold) @(posedge clk);
			#1;
			sclk = 1'b0;
		end
		repeat (hold) @(posedge clk);
		#1;
		ss_b = 1'b1;
		mosi = ~mosi;
		if (cmd == `IMSC_CMD_READ) begin
			rd_stb = 1'b1;
			@(posedge clk) #1;
			rd_stb = 1'b0;
		end
		@(posedge clk) #1;
	endtask
endmodule // imsc_host

// ---- sim/imsc_top_tb.sv ----
// self-checking bench of imsc_top driven through the host model
// assumes imsc_regs.vh on the include path
`timescale 1ns/10ps
`include "imsc_regs.vh"

module imsc_top_tb;
	reg         clk, rst_b, irq_sel, s1, s2, prog, pin_stb, o1_q, o2_q;
	reg  [1:0]  ic;
	reg  [7:0]  gap, r, s, w;
	wire        sclk, ss_b, mosi, miso, miso_oe_b, rd_stb;
	wire [7:0]  rd_val;
	wire        p1, p1_oe_b, p2, p2_oe_b, o1, o1_oe_b, o2, o2_oe_b;
	integer     h[0:1], c[0:1], n, cyc, n_mismatch, compares;
	logic [7:0] rq[$], pq[$], sq[$];

	imsc_top i_dut (.CLOCK(clk), .RST_B(rst_b), .SCLK(sclk), .SS_B(ss_b),
		.MOSI(mosi), .MISO(miso), .MISO_OE_B(miso_oe_b),
		.INPUT_CLOCK_1(ic[0]), .INPUT_CLOCK_2(ic[1]),
		.IRQ_PIN_SELECT(irq_sel), .IN1_ALARM_PIN_SELECT(s1),
		.IN2_ALARM_PIN_SELECT(s2), .IRQ_OR_IN1_ALARM_PIN(p1),
		.IRQ_OR_IN1_ALARM_PIN_OE_B(p1_oe_b), .IN2_ALARM_PIN(p2),
		.IN2_ALARM_PIN_OE_B(p2_oe_b), .OUT1_CLK(o1), .OUT1_CLK_OE_B(o1_oe_b),
		.OUT2_CLK(o2), .OUT2_CLK_OE_B(o2_oe_b));
	imsc_host i_host (.clk(clk), .sclk(sclk), .ss_b(ss_b), .mosi(mosi),
		.miso(miso), .miso_oe_b(miso_oe_b), .rd_stb(rd_stb), .rd_val(rd_val));

	always #50 clk = ~clk;

	// ****************************************
	// input clocks and result watcher
	// ****************************************
	// half period h[k] clocks, 0 stops that input
	always @(posedge clk) begin
		#1;
		for (int k = 0; k < 2; k++)
			if (h[k] != 0 && ++c[k] >= h[k]) begin
				c[k] = 0;
				ic[k] = ~ic[k];
			end
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		o1_q <= o1;
		o2_q <= o2;
		gap <= (o1 && !o1_q) ? 8'h01 : gap + 8'h01;
		if (rd_stb === 1'b1)
			cmp("register", rq.pop_front(), rd_val);
		if (pin_stb)
			cmp("pins", pq.pop_front(), {2'b00, p1 & ~p1_oe_b, p1_oe_b,
				p2 & ~p2_oe_b, p2_oe_b, o1_oe_b, o2_oe_b});
		if (o2 && !o2_q && sq.size() > 0)
			cmp("skew", sq.pop_front(), gap);
		if (cyc == 40000) begin
			n_mismatch++;
			report_and_stop;
		end
	end

	// floating pins are expected low after masking with their enable
	function [7:0] pv(input a1, input a2);
		pv = {2'b00, irq_sel ? a1 | a2 : s1 & a1, ~(irq_sel | s1), s2 & a2,
			~s2, {2{~prog}}};
	endfunction

	task cmp(input string nm, input [7:0] e, input [7:0] o);
		compares++;
		if (o !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, o);
		end
	endtask

	task wt(input integer k);
		repeat (k) @(posedge clk);
	endtask

	task pin(input [7:0] e);
		@(posedge clk) #1;
		pq.push_back(e);
		pin_stb = 1'b1;
		@(posedge clk) #1;
		pin_stb = 1'b0;
	endtask

	task wr(input [7:0] a, input [7:0] d);
		i_host.hold = 3 + $urandom % 4;
		i_host.xfer(`IMSC_CMD_WRITE, a, d);
	endtask

	task rd(input [7:0] a, input [7:0] e);
		i_host.hold = 3 + $urandom % 4;
		rq.push_back(e);
		i_host.xfer(`IMSC_CMD_READ, a, 8'h00);
	endtask

	task report_and_stop;
		if (rq.size() + pq.size() + sq.size() != 0)
			n_mismatch++;
		if (n_mismatch == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{clk, rst_b, irq_sel, pin_stb, prog, ic} = 7'h00;
		{s1, s2, gap, cyc, n_mismatch, compares} = 0;
		s1 = 1'b1;
		s2 = 1'b1;
		h[0] = 4;
		h[1] = 4;
		c[0] = 0;
		c[1] = 0;
		w = $urandom(32'h1644);
		pin(8'h17);
		wt(6);
		#1;
		rst_b = 1'b1;
		wt(20);
		pin(pv(0, 0));
		rd(8'h8b, 8'hff);
		rd(8'h8e, 8'h00);
		rd(8'h8f, 8'h00);
		rd(8'h8a, 8'h03);
		wr(8'h8c, 8'h5a);
		rd(8'h8c, 8'h00);
		pin(pv(0, 0));
		for (n = 0; n < 4; n++) begin
			w = $urandom;
			wr(8'h8b, w);
			rd(8'h8b, w | 8'hcc);
		end
		prog = 1'b1;
		pin(pv(0, 0));
		for (n = 0; n < 2; n++) begin
			wr(8'h8b, 8'h30);
			h[n] = 0;
			wt(30);
			pin(n ? pv(0, 1) : pv(1, 0));
			h[n] = 4;
			wr(8'h8b, n ? 8'h10 : 8'h20);
			pin(pv(0, 0));
			h[n] = 0;
			wt(30);
			pin(pv(0, 0));
			wt(60);
			pin(n ? pv(0, 1) : pv(1, 0));
			wr(8'h8a, n ? 8'h01 : 8'h02);
			pin(pv(0, 0));
			// reserved code 01 must keep the stopped input quiet
			wr(8'h8b, 8'h30);
			pin(pv(0, 0));
			h[n] = 4;
			wr(8'h8a, 8'h03);
		end
		wr(8'h8a, 8'h00);
		wr(8'h8b, 8'h02);
		h[0] = 2;
		h[1] = 2;
		wt(600);
		pin(pv(0, 1));
		irq_sel = 1'b1;
		pin(pv(0, 1));
		irq_sel = 1'b0;
		s1 = 1'b0;
		s2 = 1'b0;
		pin(pv(0, 1));
		s1 = 1'b1;
		s2 = 1'b1;
		wr(8'h8b, 8'h01);
		wt(600);
		pin(pv(1, 0));
		h[0] = 4;
		h[1] = 4;
		wr(8'h8b, 8'h30);
		for (n = 0; n < 2; n++) begin
			r = $urandom;
			s = $urandom;
			if (r == s)
				s = r + 8'h01;
			wr(8'h8e, r);
			wr(8'h8f, s);
			rd(8'h8f, s);
			wt(260);
			#1;
			sq.push_back(r - s);
			wt(300);
		end
		#1;
		rst_b = 1'b0;
		prog = 1'b0;
		pin(8'h17);
		wt(3);
		#1;
		rst_b = 1'b1;
		// port used two clocks after reset; the long software reset wait is ours
		wt(2);
		rd(8'h8b, 8'hff);
		rd(8'h8e, 8'h00);
		rd(8'h8f, 8'h00);
		pin(pv(0, 0));
		report_and_stop;
	end
endmodule // imsc_top_tb
